// [hw/sfl_pkg.sv]
// constants, types and register map of the serial status-flag block
// assumes one bus clock domain; link pins are synchronised in the core
// Function
// - transfer completion sets receive-full flag, status bit 7
// - without rx DMA, rx-full clears after armed status read then data read
// - with rx DMA, rx DMA done clears rx-full
// - match flag bit 6 sets when received byte equals compare value
// - match flag clears after armed read then writing 1 to bit 6
// - tx-empty bit 5 sets when buffer moves into shifter
// - without tx DMA, tx-empty clears after armed read then data write
// - without tx DMA, data write without prior armed status read is discarded
// - with tx DMA, tx DMA done clears tx-empty
// - idle shifter takes written byte, tx-empty set within two cycles
// - at shift end a queued byte moves to shifter, tx-empty sets
// - with nothing queued tx-empty stays set and nothing moves
// - continuing transfers without new data resend the last byte
// - fault flag bit 4 sets when master sees select input low
// - fault detection only with master, detect enable, select output off
// - fault flag clears after armed read then control-one write
// - status bits 3 to 0 read zero
// - byte ending while receive buffer full is dropped silently
// - fault clears master select, disables outputs, aborts transfer
package sfl_pkg;
	// register indices; byte address is four times the index
	localparam logic [2:0] IDX_CTRL1 = 3'h0;
	localparam logic [2:0] IDX_CTRL2 = 3'h1;
	localparam logic [2:0] IDX_STAT = 3'h3;
	localparam logic [2:0] IDX_DATA = 3'h5;
	localparam logic [2:0] IDX_MATCH = 3'h7;
	// status bit positions
	localparam int B_RXF = 7;
	localparam int B_MAT = 6;
	localparam int B_TXE = 5;
	localparam int B_FLT = 4;
	// control one / control two bit positions
	localparam int B_MASTER_SELECT = 4;
	localparam int B_SELECT_OUTPUT_ENABLE = 1;
	localparam int B_FDEN = 4;
	localparam int B_RXDMA = 2;
	localparam int B_TXDMA = 5;
	localparam logic [7:0] CTRL1_RST = 8'h04;
	localparam logic [7:0] CTRL2_RST = 8'h00;
	localparam logic [7:0] MATCH_RST = 8'h00;
	localparam logic [2:0] LAST_BIT = 3'h7;
	// idle pin levels {data, select, link clock}, used as synchroniser reset
	localparam logic [2:0] SYNC_IDLE = 3'h2;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	// shifter states, gray along idle -> shift -> done
	typedef enum logic [1:0] {
		SH_IDLE = 2'b00,
		SH_RUN = 2'b01,
		SH_DONE = 2'b11
	} sfl_sh_e;
	// the four status flags
	typedef struct packed {
		logic rx_full_flag;
		logic rx_match_flag;
		logic tx_empty_flag;
		logic master_fault_flag;
	} sfl_flags_s;
	localparam sfl_flags_s FLAGS_RST = 4'h2;
endpackage

// [hw/sfl_core.sv]
// status-flag logic of a byte-wide serial port with an AXI4-Lite slave
// assumes link pins come from outside the bus clock domain
`timescale 1ns/1ps
module sfl_core
	import sfl_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// axi4-lite write
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// dma completion and requests
	input wire logic rx_dma_done,
	input wire logic tx_dma_done,
	output logic rx_dma_req,
	output logic tx_dma_req,
	// serial link pins
	input wire logic link_clk,
	input wire logic select_in_n,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_en
);
	// register index decode, shared by read and write paths
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [2:0] idx);
		hit = (a[ADDR_W-1:2] == {{(ADDR_W-5){1'b0}}, idx}) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = hit(a, IDX_CTRL1) | hit(a, IDX_CTRL2) | hit(a, IDX_STAT)
			| hit(a, IDX_DATA) | hit(a, IDX_MATCH);
	endfunction

	logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic [7:0] ctrl1_r, ctrl2_r, match_r, rx_byte_r, tx_buf_r, last_r, sh_r;
	logic tx_full_r, loaded_r, done_r;
	logic [2:0] cnt_r;
	sfl_sh_e state_r;
	sfl_flags_s flag_r, arm_r;
	logic [2:0] s1_r, s2_r;
	logic clk_d_r;
	logic sdo_r, sdo_en_r, rxq_r, txq_r;

	// two-flop synchronisers for link clock, select and data
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_sync
			always_ff @(posedge ref_clk or posedge reset)
			begin
				if (reset)
				begin
					// reset to the idle pin level so no false edge follows reset
					s1_r[gi] <= SYNC_IDLE[gi];
					s2_r[gi] <= SYNC_IDLE[gi];
				end
				else
				begin
					s1_r[gi] <= (gi == 0) ? link_clk : (gi == 1) ? select_in_n : serial_in;
					s2_r[gi] <= s1_r[gi];
				end
			end
		end
	endgenerate

	logic lclk, ss_low, sdi, rise, fall;
	assign lclk = s2_r[0];
	assign ss_low = ~s2_r[1];
	assign sdi = s2_r[2];
	assign rise = lclk & ~clk_d_r;
	assign fall = ~lclk & clk_d_r;

	// bus handshake decode; valids are held until ready
	logic wr_take, rd_take, wr_ok;
	assign wr_take = awready_r & s_axi_awvalid & s_axi_wvalid;
	assign rd_take = arready_r & s_axi_arvalid;
	assign wr_ok = wr_take & s_axi_wstrb[0];

	logic rd_s, rd_d, wr_c1, wr_c2, wr_s, wr_d, wr_m;
	assign rd_s = rd_take & hit(s_axi_araddr, IDX_STAT);
	assign rd_d = rd_take & hit(s_axi_araddr, IDX_DATA);
	assign wr_c1 = wr_ok & hit(s_axi_awaddr, IDX_CTRL1);
	assign wr_c2 = wr_ok & hit(s_axi_awaddr, IDX_CTRL2);
	assign wr_s = wr_ok & hit(s_axi_awaddr, IDX_STAT);
	assign wr_d = wr_ok & hit(s_axi_awaddr, IDX_DATA);
	assign wr_m = wr_ok & hit(s_axi_awaddr, IDX_MATCH);

	logic master, rxdma, txdma, fault_evt;
	assign master = ctrl1_r[B_MASTER_SELECT];
	assign rxdma = ctrl2_r[B_RXDMA];
	assign txdma = ctrl2_r[B_TXDMA];
	// detection only in the one legal configuration
	assign fault_evt = master & ctrl2_r[B_FDEN] & ~ctrl1_r[B_SELECT_OUTPUT_ENABLE] & ss_low;

	// events feeding the flags
	logic rx_set, mat_set, rx_clr, mat_clr, load, txe_clr, flt_clr, d_acc, move;
	assign rx_set = done_r & ~flag_r.rx_full_flag;
	// compare the byte just shifted in, not the one it replaces
	assign mat_set = rx_set & (sh_r == match_r);
	assign rx_clr = rxdma ? rx_dma_done : (rd_d & arm_r.rx_full_flag);
	assign mat_clr = wr_s & s_axi_wdata[B_MAT] & arm_r.rx_match_flag;
	assign d_acc = wr_d & (arm_r.tx_empty_flag | txdma);
	assign txe_clr = txdma ? tx_dma_done : d_acc;
	assign load = tx_full_r & ~loaded_r & (state_r == SH_IDLE);
	// any buffer-to-shifter move, from idle or at the end of a byte
	assign move = load | (done_r & tx_full_r);
	assign flt_clr = wr_c1 & arm_r.master_fault_flag;

	// axi write channel; address and data are taken together
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OK;
		end
		else
		begin
			awready_r <= s_axi_awvalid & s_axi_wvalid & ~awready_r & ~bvalid_r;
			wready_r <= s_axi_awvalid & s_axi_wvalid & ~awready_r & ~bvalid_r;
			if (wr_take)
			begin
				bvalid_r <= 1'b1;
				bresp_r <= mapped(s_axi_awaddr) ? RESP_OK : RESP_ERR;
			end
			else if (s_axi_bready)
				bvalid_r <= 1'b0;
		end
	end

	// axi read channel; data sampled at the taking edge
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= RESP_OK;
		end
		else
		begin
			arready_r <= s_axi_arvalid & ~arready_r & ~rvalid_r;
			if (rd_take)
			begin
				rvalid_r <= 1'b1;
				rresp_r <= mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
				rdata_r <= 32'h0;
				if (hit(s_axi_araddr, IDX_CTRL1))
					rdata_r[7:0] <= ctrl1_r;
				if (hit(s_axi_araddr, IDX_CTRL2))
					rdata_r[7:0] <= ctrl2_r;
				if (hit(s_axi_araddr, IDX_STAT))
					rdata_r[7:0] <= {flag_r, 4'h0};
				if (hit(s_axi_araddr, IDX_DATA))
					rdata_r[7:0] <= rx_byte_r;
				if (hit(s_axi_araddr, IDX_MATCH))
					rdata_r[7:0] <= match_r;
			end
			else if (s_axi_rready)
				rvalid_r <= 1'b0;
		end
	end

	// control registers; a fault forces slave mode
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			ctrl1_r <= CTRL1_RST;
			ctrl2_r <= CTRL2_RST;
			match_r <= MATCH_RST;
		end
		else
		begin
			if (wr_c1)
				ctrl1_r <= s_axi_wdata[7:0];
			if (fault_evt)
				ctrl1_r[B_MASTER_SELECT] <= 1'b0;
			if (wr_c2)
				ctrl2_r <= s_axi_wdata[7:0];
			if (wr_m)
				match_r <= s_axi_wdata[7:0];
		end
	end

	// flags: every set beats a same-cycle clear
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			flag_r <= FLAGS_RST;
		else
		begin
			if (rx_set)
				flag_r.rx_full_flag <= 1'b1;
			else if (rx_clr)
				flag_r.rx_full_flag <= 1'b0;
			if (mat_set)
				flag_r.rx_match_flag <= 1'b1;
			else if (mat_clr)
				flag_r.rx_match_flag <= 1'b0;
			if (move)
				flag_r.tx_empty_flag <= 1'b1;
			else if (txe_clr)
				flag_r.tx_empty_flag <= 1'b0;
			if (fault_evt)
				flag_r.master_fault_flag <= 1'b1;
			else if (flt_clr)
				flag_r.master_fault_flag <= 1'b0;
		end
	end

	// arming: a status read saw the flag set; dropped when flag clears
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			arm_r <= 4'h0;
		else
		begin
			if (rx_clr & ~rx_set)
				arm_r.rx_full_flag <= 1'b0;
			else if (rd_s & flag_r.rx_full_flag)
				arm_r.rx_full_flag <= 1'b1;
			if (mat_clr & ~mat_set)
				arm_r.rx_match_flag <= 1'b0;
			else if (rd_s & flag_r.rx_match_flag)
				arm_r.rx_match_flag <= 1'b1;
			if (txe_clr & ~move)
				arm_r.tx_empty_flag <= 1'b0;
			else if (rd_s & flag_r.tx_empty_flag)
				arm_r.tx_empty_flag <= 1'b1;
			if (flt_clr & ~fault_evt)
				arm_r.master_fault_flag <= 1'b0;
			else if (rd_s & flag_r.master_fault_flag)
				arm_r.master_fault_flag <= 1'b1;
		end
	end

	// transmit buffer; one byte may wait behind the shifter
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			tx_buf_r <= 8'h0;
			tx_full_r <= 1'b0;
		end
		else
		begin
			if (d_acc)
				tx_buf_r <= s_axi_wdata[7:0];
			if (d_acc)
				tx_full_r <= 1'b1;
			else if (move)
				tx_full_r <= 1'b0;
		end
	end

	// shifter, mode 0: sample on link rise, change on fall, msb first
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			state_r <= SH_IDLE;
			sh_r <= 8'h0;
			last_r <= 8'h0;
			cnt_r <= 3'h0;
			loaded_r <= 1'b0;
			done_r <= 1'b0;
			clk_d_r <= 1'b0;
			rx_byte_r <= 8'h0;
		end
		else
		begin
			clk_d_r <= lclk;
			done_r <= 1'b0;
			if (load)
			begin
				sh_r <= tx_buf_r;
				last_r <= tx_buf_r;
				loaded_r <= 1'b1;
			end
			if (rx_set)
				rx_byte_r <= sh_r;
			case (state_r)
				SH_IDLE:
					if ((master & loaded_r & ~fault_evt) | (~master & ss_low))
					begin
						state_r <= SH_RUN;
						loaded_r <= 1'b0;
						cnt_r <= 3'h0;
					end
				SH_RUN:
					if (fault_evt | (~master & ~ss_low))
						state_r <= SH_IDLE;
					else if (rise)
					begin
						sh_r <= {sh_r[6:0], sdi};
						cnt_r <= cnt_r + 3'h1;
						if (cnt_r == LAST_BIT)
						begin
							state_r <= SH_DONE;
							done_r <= 1'b1;
						end
					end
				SH_DONE:
				begin
					// queued byte follows; otherwise the last one repeats
					if (tx_full_r)
					begin
						sh_r <= tx_buf_r;
						last_r <= tx_buf_r;
					end
					else
						sh_r <= last_r;
					cnt_r <= 3'h0;
					if (master & tx_full_r & ~fault_evt)
						state_r <= SH_RUN;
					else if (~master & ss_low)
						state_r <= SH_RUN;
					else
						state_r <= SH_IDLE;
				end
				default:
					state_r <= SH_IDLE;
			endcase
		end
	end

	// registered pin and request outputs; fault turns the driver off
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			sdo_r <= 1'b0;
			sdo_en_r <= 1'b0;
			rxq_r <= 1'b0;
			txq_r <= 1'b0;
		end
		else
		begin
			if (fall | (state_r != SH_RUN))
				sdo_r <= sh_r[7];
			sdo_en_r <= ~fault_evt & (master ? (state_r != SH_IDLE) : ss_low);
			rxq_r <= rxdma & flag_r.rx_full_flag;
			txq_r <= txdma & flag_r.tx_empty_flag;
		end
	end

	// straight from flops
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign serial_out = sdo_r;
	assign serial_out_en = sdo_en_r;
	assign rx_dma_req = rxq_r;
	assign tx_dma_req = txq_r;
endmodule

// [verification/sfl_monitor.sv]
// port checker for sfl_core
// assumes one bus clock domain and an async active-high reset
`timescale 1ns/1ps
module sfl_monitor
	import sfl_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// dma
	input wire logic rx_dma_done,
	input wire logic rx_dma_req
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	logic [ADDR_W-1:0] raddr_r;
	// address of the read under way, so read data can be judged per register
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
			raddr_r <= '0;
		else if (s_axi_arvalid && s_axi_arready)
			raddr_r <= s_axi_araddr;
	AST_AW_W_PAIR: assert property (s_axi_awready |-> s_axi_wready)
		else $error("address and data ready split");
	AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("write ready longer than one cycle");
	AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
		else $error("write response late");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
		else $error("read data moved while waiting");
	AST_STAT_LOW: assert property (s_axi_rvalid && raddr_r == ADDR_W'({IDX_STAT, 2'h0}) |->
		s_axi_rdata[3:0] == 4'h0 && s_axi_rdata[31:8] == 24'h0)
		else $error("status unused bits not zero");
	AST_RXDMA_CLR: assert property (rx_dma_done && rx_dma_req |-> ##[1:3] !rx_dma_req)
		else $error("rx request stays after dma done");
endmodule

// [verification/sfl_peer.sv]
// remote serial master: drives link clock, select and data, msb first
// assumes the device samples on the rising link clock
`timescale 1ns/1ps
module sfl_peer
(
	// link
	output logic link_clk,
	output logic select_in_n,
	output logic serial_in,
	input wire logic serial_out
);
	// clock stands low outside frames
	initial
	begin
		link_clk = 1'b0;
		select_in_n = 1'b1;
		serial_in = 1'b0;
	end
	// one byte, 320 ns per bit; data changes with the falling clock
	task automatic frame(input logic [7:0] d, output logic [7:0] q);
		select_in_n = 1'b0;
		#200;
		for (int i = 7; i >= 0; i--)
		begin
			serial_in = d[i];
			#160 link_clk = 1'b1;
			q[i] = serial_out;
			#160 link_clk = 1'b0;
		end
		#200 select_in_n = 1'b1;
		serial_in = ~serial_in; // released line shows no stale level
	endtask
	// a second master pulls select low without clocking
	task automatic grab();
		select_in_n = 1'b0;
		#400 select_in_n = 1'b1;
	endtask
endmodule

// [verification/tb.sv]
// bench for sfl_core: bus master tasks, serial peer, expected flags
// assumes the core answers the bus within the watchdog span
`timescale 1ns/1ps
module tb;
	import sfl_pkg::*;
	localparam logic [7:0] A_C1 = 8'h00;
	localparam logic [7:0] A_C2 = 8'h04;
	localparam logic [7:0] A_ST = 8'h0c;
	localparam logic [7:0] A_D = 8'h14;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic rx_dma_done = 1'b0, tx_dma_done = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata;
	logic rx_dma_req, tx_dma_req, link_clk, select_in_n, serial_in, serial_out, serial_out_en;
	logic [7:0] got, b0, b1, q;
	// model of the transmit stream: bytes accepted, and the last one sent
	logic [7:0] tx_m [$];
	logic [7:0] last_m = 8'h00;
	// a line that is not driven shows the inverse of the stale level
	logic miso_line;
	assign miso_line = serial_out_en ? serial_out : ~serial_out;
	logic [7:0] c1t [4] = '{8'h04, 8'h16, 8'h14, 8'h14};
	logic [7:0] c2t [4] = '{8'h10, 8'h10, 8'h00, 8'h10};
	int n_errors = 0;
	int checked = 0;
	sfl_core u_dut (.*);
	sfl_peer u_peer (
		.link_clk(link_clk),
		.select_in_n(select_in_n),
		.serial_in(serial_in),
		.serial_out(miso_line)
	);
	// bus clock, 40 ns
	always #20 ref_clk = ~ref_clk;
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		checked++;
		if (s !== e)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	// ready and answer sampled at the rising edge; released right after it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do @(posedge ref_clk); while (s_axi_awready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_bready <= 1'b1;
		do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata[7:0];
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// a status read also arms the clear of every flag it sees set
	task automatic st(input logic [7:0] e);
		rd(A_ST, got);
		chk("status", e, got);
	endtask
	// queued byte goes out next; with none queued the last one repeats
	task automatic xfer(input logic [7:0] d, output logic [7:0] r);
		logic [7:0] e;
		if (tx_m.size() > 0)
			e = tx_m.pop_front();
		else
			e = last_m;
		last_m = e;
		u_peer.frame(d, r);
		chk("tx model", e, r);
		repeat (4) @(posedge ref_clk);
	endtask
	task automatic report_and_stop();
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// watchdog, about nine times the expected run
	initial
	begin
		#200000;
		n_errors++;
		report_and_stop();
	end
	// main sequence
	initial
	begin
		void'($urandom(57341));
		b0 = 8'($urandom) | 8'h01;
		b1 = 8'($urandom) & 8'hfe; // even, so it never equals b0
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		st(8'h20);
		rd(A_C1, got);
		chk("ctrl1", CTRL1_RST, got);
		rd(8'h08, got);
		chk("resp", {6'h0, RESP_ERR}, {6'h0, resp});
		wr(8'h08, 8'hff);
		chk("bresp", {6'h0, RESP_ERR}, {6'h0, resp});
		wr(A_D, b1);
		tx_m.push_back(b1);
		st(8'h20);
		wr(A_D, ~b1);
		tx_m.push_back(~b1);
		st(8'h00);
		wr(A_D, 8'h00);
		xfer(b0, q);
		chk("tx", b1, q);
		st(8'ha0);
		xfer(~b0, q);
		chk("tx", ~b1, q);
		xfer(b1, q);
		chk("tx", ~b1, q);
		rd(A_D, got);
		chk("rx", b0, got);
		st(8'h20);
		wr(8'h1c, b1);
		xfer(b1, q);
		chk("tx", ~b1, q);
		wr(A_ST, 8'h40);
		st(8'he0);
		wr(A_ST, 8'h40);
		st(8'ha0);
		rd(A_D, got);
		chk("rx", b1, got);
		// three configurations that must ignore select, then the live one
		foreach (c1t[i])
		begin
			wr(A_C2, c2t[i]);
			wr(A_C1, c1t[i]);
			u_peer.grab();
			@(posedge ref_clk);
			st(i == 3 ? 8'h30 : 8'h20);
		end
		rd(A_C1, got);
		chk("ctrl1", 8'h04, got);
		chk("oe", 8'h00, {7'h0, serial_out_en});
		wr(A_C1, 8'h04);
		st(8'h20);
		wr(A_C2, 8'h24);
		xfer(b0, q);
		chk("rxreq", 8'h01, {7'h0, rx_dma_req});
		chk("txreq", 8'h01, {7'h0, tx_dma_req});
		rx_dma_done <= 1'b1;
		@(posedge ref_clk);
		rx_dma_done <= 1'b0;
		tx_dma_done <= 1'b1;
		@(posedge ref_clk);
		tx_dma_done <= 1'b0;
		@(posedge ref_clk);
		st(8'h00);
		chk("rxreq", 8'h00, {7'h0, rx_dma_req});
		chk("txreq", 8'h00, {7'h0, tx_dma_req});
		wr(A_D, b0);
		st(8'h20);
		chk("txreq", 8'h01, {7'h0, tx_dma_req});
		report_and_stop();
	end
endmodule
bind sfl_core sfl_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);
